// File: core/schd_consts.svh
// Constants for the serial controller host port decoder
// Notes on behaviour
// - Dual controller map repeats every 64 bytes
// - Read with A6-A5 at 11 sets break
// - Break mode plus low console line raises NMI
// - Reset or A6-A5 at 10 read clears break
// - Integrated controller only at even addresses
// - First integrated write becomes bus configuration
// - Serial-or-DMA select follows address bit 6
// - Channel select high at config, else A5
// - Byte configuration fields: swap, lane, ack, shift
// - Shift-left takes register from lines 5-1
// - Address strobe is inverted latch enable
// - Integrated map: DMA, channel B, channel A
// - Multi controller 256 bytes, width by map
// - Port select from A7, data/command low
// - Word configuration fields: width, ack, shift
// - Shift-right takes register from lines 6-0
// - Configuration register unreachable after capture
`ifndef SCHD_CONSTS_SVH
`define SCHD_CONSTS_SVH

// Peripheral base, must sit on a 1 Kbyte boundary
`define SCHD_PERIPH_BASE   16'h0400
`define SCHD_BASE_HI       15
`define SCHD_BASE_LO       10

// Window offset bits that pick a controller
`define SCHD_OFF_W         10
`define SCHD_REGION_DUAL   3'h0
`define SCHD_REGION_INTEG  3'h1
`define SCHD_REGION_MULTI  2'h1

// Address bits inside the window
`define SCHD_BIT_A5        5
`define SCHD_BIT_A6        6
`define SCHD_BIT_A7        7
`define SCHD_BREAK_SET     2'h3
`define SCHD_BREAK_CLR     2'h2

// Byte configuration fields
`define SCHD_BCFG_SWAP     7
`define SCHD_BCFG_LANE     6
`define SCHD_BCFG_ACK_HI   2
`define SCHD_BCFG_ACK_LO   1
`define SCHD_BCFG_SHIFT    0
`define SCHD_BCFG_RESET    8'h00

// Word configuration fields
`define SCHD_WCFG_RSV_HI   15
`define SCHD_WCFG_RSV_LO   3
`define SCHD_WCFG_BUS16    2
`define SCHD_WCFG_ACK      1
`define SCHD_WCFG_SHIFT    0
`define SCHD_WCFG_RESET    16'h0000

// Synchroniser stage idle levels: rxd, bhe, wr, rd, ale, ad
`define SCHD_SYNC_W        21
`define SCHD_SYNC_RESET    21'h1e0000

`endif

// File: core/schd_pkg.sv
// Types shared by the host port decoder
`default_nettype none
package schd_pkg;
	// Controller selected by the latched address
	typedef enum logic [1:0]
	{
		SCHD_RGN_NONE  = 2'b00,
		SCHD_RGN_DUAL  = 2'b01,
		SCHD_RGN_INTEG = 2'b10,
		SCHD_RGN_MULTI = 2'b11
	} schd_region_t;
endpackage
`default_nettype wire

// File: core/schd_sync.sv
// Two flip-flop synchroniser for the host pins
`include "schd_consts.svh"
`default_nettype none
module schd_sync
	import schd_pkg::*;
#(
	parameter int                WIDTH   = `SCHD_SYNC_W,
	parameter logic [WIDTH-1:0]  RST_VAL = `SCHD_SYNC_RESET
)
(
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Asynchronous pins and their synchronised copy
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	////////////////////////////////////////////////////////////////////
	// First stage is read only by the second
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			meta_r   <= RST_VAL;
			sync_out <= RST_VAL;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule
`default_nettype wire

// File: core/schd_decode.sv
// Host port decoder for three serial controllers
`include "schd_consts.svh"
`default_nettype none
module schd_decode
	import schd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Host multiplexed bus pins
	input  wire logic [15:0] ad_in,
	input  wire logic        ale_in,
	input  wire logic        rd_n_in,
	input  wire logic        wr_n_in,
	input  wire logic        bhe_n_in,
	// Console received data line
	input  wire logic        console_rxd_in,
	// Common controller strobes
	output logic             addr_strobe_n_out,
	output logic             ctrl_rd_n_out,
	output logic             ctrl_wr_n_out,
	// Dual channel controller
	output logic             dual_cs_n_out,
	output logic             dual_chan_a_out,
	output logic      [3:0]  dual_reg_out,
	// Integrated controller
	output logic             integ_cs_n_out,
	output logic             serial_or_dma_select_out,
	output logic             integ_chan_sel_out,
	output logic      [4:0]  integ_reg_out,
	output logic             integ_cfg_access_out,
	// Multi-protocol controller
	output logic             multi_cs_n_out,
	output logic             port_select_out,
	output logic             data_cmd_sel_out,
	output logic             multi_wide_out,
	output logic      [6:0]  multi_reg_out,
	output logic             multi_cfg_access_out,
	// Captured byte configuration
	output logic             byte_cfg_valid_out,
	output logic             byte_swap_out,
	output logic             even_low_lane_out,
	output logic             integ_dbl_ack_out,
	output logic             integ_shift_left_out,
	// Captured word configuration
	output logic             word_cfg_valid_out,
	output logic             word_cfg_fault_out,
	output logic             multi_bus16_out,
	output logic             multi_dbl_ack_out,
	output logic             multi_shift_right_out,
	// Console break
	output logic             console_break_out,
	output logic             nmi_out
);

	////////////////////////////////////////////////////////////////////
	// Declarations
	logic [`SCHD_SYNC_W-1:0] pins_s;
	logic [15:0]             ad_s;
	logic                    ale_s;
	logic                    rd_n_s;
	logic                    wr_n_s;
	logic                    rxd_s;
	logic                    ale_q_r;
	logic                    rd_n_q_r;
	logic                    wr_n_q_r;
	logic                    ale_fall;
	logic                    rd_fall;
	logic                    wr_rise;
	logic [15:0]             addr_r;
	logic [`SCHD_OFF_W-1:0]  off;
	schd_region_t            region_r;
	schd_region_t            region_nxt;
	logic [7:0]              byte_cfg_r;
	logic [15:0]             word_cfg_r;
	logic                    byte_armed_r;
	logic                    word_armed_r;
	logic                    break_r;
	logic                    nmi_r;
	logic [1:0]              brk_field;

	// Window base held as a vector so that its top bits can be sliced
	localparam logic [15:0]  PERIPH_BASE = `SCHD_PERIPH_BASE;

	////////////////////////////////////////////////////////////////////
	// Region decode of a latched host address
	function automatic schd_region_t region_of(input logic [15:0] a);
		logic [`SCHD_OFF_W-1:0] o;
		o = a[`SCHD_OFF_W-1:0];
		region_of = SCHD_RGN_NONE;
		if (a[`SCHD_BASE_HI:`SCHD_BASE_LO] ==
			PERIPH_BASE[`SCHD_BASE_HI:`SCHD_BASE_LO])
		begin
			if (o[9:8] == `SCHD_REGION_MULTI)
				region_of = SCHD_RGN_MULTI;
			else if (o[9:7] == `SCHD_REGION_INTEG && !o[0])
				region_of = SCHD_RGN_INTEG;
			else if (o[9:7] == `SCHD_REGION_DUAL && !o[0])
				region_of = SCHD_RGN_DUAL;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	schd_sync #(
		.WIDTH   (`SCHD_SYNC_W),
		.RST_VAL (`SCHD_SYNC_RESET)
	) u_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.async_in ({console_rxd_in, bhe_n_in, wr_n_in, rd_n_in,
			ale_in, ad_in}),
		.sync_out (pins_s)
	);

	// Unpack the synchronised pins
	assign ad_s   = pins_s[15:0];
	assign ale_s  = pins_s[16];
	assign rd_n_s = pins_s[17];
	assign wr_n_s = pins_s[18];
	assign rxd_s  = pins_s[20];

	////////////////////////////////////////////////////////////////////
	// Edge detectors on the synchronised strobes
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ale_q_r  <= 1'b0;
			rd_n_q_r <= 1'b1;
			wr_n_q_r <= 1'b1;
		end
		else
		begin
			ale_q_r  <= ale_s;
			rd_n_q_r <= rd_n_s;
			wr_n_q_r <= wr_n_s;
		end
	end

	// Address latch at ALE fall, read at strobe fall, write at its end
	assign ale_fall = ale_q_r & ~ale_s;
	assign rd_fall  = rd_n_q_r & ~rd_n_s;
	assign wr_rise  = ~wr_n_q_r & wr_n_s;
	assign off      = addr_r[`SCHD_OFF_W-1:0];
	assign region_nxt = region_of(ad_s);

	////////////////////////////////////////////////////////////////////
	// Address latch and region
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			addr_r   <= 16'h0000;
			region_r <= SCHD_RGN_NONE;
		end
		else if (ale_fall)
		begin
			addr_r   <= ad_s;
			region_r <= region_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Strobes to the controllers
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			addr_strobe_n_out <= 1'b1;
			ctrl_rd_n_out     <= 1'b1;
			ctrl_wr_n_out     <= 1'b1;
		end
		else
		begin
			addr_strobe_n_out <= ~ale_s;
			ctrl_rd_n_out     <= rd_n_s;
			ctrl_wr_n_out     <= wr_n_s;
		end
	end

	// Chip selects follow the strobes for the decoded region
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			dual_cs_n_out  <= 1'b1;
			integ_cs_n_out <= 1'b1;
			multi_cs_n_out <= 1'b1;
		end
		else
		begin
			dual_cs_n_out  <= ~((region_r == SCHD_RGN_DUAL) &
				~(rd_n_s & wr_n_s));
			integ_cs_n_out <= ~((region_r == SCHD_RGN_INTEG) &
				~(rd_n_s & wr_n_s));
			multi_cs_n_out <= ~((region_r == SCHD_RGN_MULTI) &
				~(rd_n_s & wr_n_s));
		end
	end

	////////////////////////////////////////////////////////////////////
	// Dual channel register select, mirrored every 64 bytes
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			dual_chan_a_out <= 1'b0;
			dual_reg_out    <= 4'h0;
		end
		else
		begin
			dual_chan_a_out <= off[`SCHD_BIT_A5];
			dual_reg_out    <= off[4:1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Console break mode, set and cleared by dual controller reads
	assign brk_field = off[`SCHD_BIT_A6:`SCHD_BIT_A5];

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			break_r <= 1'b0;
		else if (rd_fall && region_r == SCHD_RGN_DUAL)
		begin
			if (brk_field == `SCHD_BREAK_SET)
				break_r <= 1'b1;
			else if (brk_field == `SCHD_BREAK_CLR)
				break_r <= 1'b0;
		end
	end

	// NMI while break mode sees a low on the console line
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			nmi_r <= 1'b0;
		else
			nmi_r <= break_r & ~rxd_s;
	end

	assign console_break_out = break_r;
	assign nmi_out           = nmi_r;

	////////////////////////////////////////////////////////////////////
	// Integrated controller byte configuration capture
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			byte_armed_r <= 1'b1;
			byte_cfg_r   <= `SCHD_BCFG_RESET;
		end
		else if (wr_rise && region_r == SCHD_RGN_INTEG && byte_armed_r)
		begin
			byte_armed_r <= 1'b0;
			byte_cfg_r   <= ad_s[7:0];
		end
	end

	// Integrated controller select lines and register index
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			serial_or_dma_select_out <= 1'b0;
			integ_chan_sel_out       <= 1'b1;
			integ_reg_out            <= 5'h00;
		end
		else
		begin
			serial_or_dma_select_out <= off[`SCHD_BIT_A6];
			integ_chan_sel_out       <= byte_armed_r |
				off[`SCHD_BIT_A5];
			if (!byte_cfg_r[`SCHD_BCFG_SHIFT])
				integ_reg_out <= off[5:1];
			else
				integ_reg_out <= off[4:0];
		end
	end

	assign integ_cfg_access_out = byte_armed_r &
		(region_r == SCHD_RGN_INTEG);

	// Byte configuration fields
	assign byte_cfg_valid_out   = ~byte_armed_r;
	assign byte_swap_out        = byte_cfg_r[`SCHD_BCFG_SWAP];
	assign even_low_lane_out    = byte_cfg_r[`SCHD_BCFG_LANE];
	assign integ_dbl_ack_out    =
		&byte_cfg_r[`SCHD_BCFG_ACK_HI:`SCHD_BCFG_ACK_LO];
	assign integ_shift_left_out = ~byte_cfg_r[`SCHD_BCFG_SHIFT];

	////////////////////////////////////////////////////////////////////
	// Multi-protocol controller word configuration capture
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			word_armed_r <= 1'b1;
			word_cfg_r   <= `SCHD_WCFG_RESET;
		end
		else if (wr_rise && region_r == SCHD_RGN_MULTI && word_armed_r)
		begin
			word_armed_r <= 1'b0;
			word_cfg_r   <= ad_s;
		end
	end

	// Multi-protocol select lines, width and register index
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			port_select_out  <= 1'b0;
			data_cmd_sel_out <= 1'b0;
			multi_wide_out   <= 1'b0;
			multi_reg_out    <= 7'h00;
		end
		else
		begin
			port_select_out  <= off[`SCHD_BIT_A7];
			data_cmd_sel_out <= 1'b0;
			multi_wide_out   <= ~off[`SCHD_BIT_A6];
			if (word_cfg_r[`SCHD_WCFG_SHIFT])
				multi_reg_out <= off[6:0];
			else
				multi_reg_out <= off[7:1];
		end
	end

	assign multi_cfg_access_out = word_armed_r &
		(region_r == SCHD_RGN_MULTI);

	// Word configuration fields, reserved bits must read back zero
	assign word_cfg_valid_out    = ~word_armed_r;
	assign word_cfg_fault_out    =
		|word_cfg_r[`SCHD_WCFG_RSV_HI:`SCHD_WCFG_RSV_LO];
	assign multi_bus16_out       = word_cfg_r[`SCHD_WCFG_BUS16];
	assign multi_dbl_ack_out     = word_cfg_r[`SCHD_WCFG_ACK];
	assign multi_shift_right_out = word_cfg_r[`SCHD_WCFG_SHIFT];

endmodule
`default_nettype wire

// File: sim/schd_host_model.sv
// Host processor model driving the multiplexed address/data bus
`default_nettype none
module schd_host_model
(
	// Clock
	input  wire logic        clk_in,
	// Host bus pins
	output logic      [15:0] ad_out,
	output logic             ale_out,
	output logic             rd_n_out,
	output logic             wr_n_out,
	output logic             bhe_n_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bus idle at time zero
	initial
	begin
		ad_out = 16'hffff;
		ale_out = 1'b0;
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		bhe_n_out = 1'b1;
	end

	// Address phase, then strobe held low for six clocks
	task automatic start(input logic wr, input logic [15:0] a, d);
		@(negedge clk_in);
		ale_out = 1'b1;
		ad_out = a;
		repeat (3) @(negedge clk_in);
		ale_out = 1'b0;
		repeat (3) @(negedge clk_in);
		ad_out = wr ? d : ~a; // A released bus never shows the address
		if (wr)
			wr_n_out = 1'b0;
		else
			rd_n_out = 1'b0;
		repeat (6) @(negedge clk_in);
	endtask

	// Strobe release, data hold, then idle gap
	task automatic finish();
		rd_n_out = 1'b1;
		wr_n_out = 1'b1;
		repeat (3) @(negedge clk_in);
		ad_out = ~ad_out;
		repeat (3) @(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// File: sim/schd_decode_assertions.sv
// Concurrent checks on the host port decoder ports
`default_nettype none
module schd_decode_assertions
(
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       rst_in,
	// Watched pins
	input wire logic       ale_in,
	input wire logic       console_rxd_in,
	input wire logic       addr_strobe_n_out,
	input wire logic       ctrl_rd_n_out,
	input wire logic       dual_cs_n_out,
	input wire logic       integ_cs_n_out,
	input wire logic       multi_cs_n_out,
	input wire logic       dual_chan_a_out,
	input wire logic       integ_chan_sel_out,
	input wire logic [4:0] integ_reg_out,
	input wire logic       byte_cfg_valid_out,
	input wire logic       byte_swap_out,
	input wire logic       integ_shift_left_out,
	input wire logic [6:0] multi_reg_out,
	input wire logic       multi_wide_out,
	input wire logic       multi_shift_right_out,
	input wire logic       data_cmd_sel_out,
	input wire logic       console_break_out,
	input wire logic       nmi_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// Break armed with the console line held low
	sequence s_break_low;
		(console_break_out && !console_rxd_in) [*6];
	endsequence
	sequence s_break_idle;
		(!console_break_out || console_rxd_in) [*6];
	endsequence

	a_strobe_follows_ale: assert property (
		$rose(ale_in) |-> ##[1:5] !addr_strobe_n_out)
		else $error("strobe late");
	a_cmd_held_low: assert property (!data_cmd_sel_out)
		else $error("cmd select high");
	a_one_select: assert property (
		$onehot0({!dual_cs_n_out, !integ_cs_n_out, !multi_cs_n_out}))
		else $error("two selects");
	a_break_nmi: assert property (s_break_low |=> nmi_out)
		else $error("no nmi");
	a_nmi_quiet: assert property (s_break_idle |=> !nmi_out)
		else $error("stray nmi");
	a_break_on_read: assert property (
		$rose(console_break_out) |-> dual_chan_a_out ##[0:2] !ctrl_rd_n_out)
		else $error("bad break set");
	a_break_clear: assert property (
		$fell(console_break_out) |-> !dual_chan_a_out)
		else $error("bad break clear");
	a_integ_shift: assert property (
		!integ_cs_n_out && byte_cfg_valid_out && $past(byte_cfg_valid_out)
		&& integ_shift_left_out |-> integ_reg_out[4] == integ_chan_sel_out)
		else $error("integ index");
	a_multi_shift: assert property (
		!multi_cs_n_out && multi_shift_right_out
		|-> multi_reg_out[6] != multi_wide_out)
		else $error("multi index");
	a_cfg_frozen: assert property (
		byte_cfg_valid_out && $past(byte_cfg_valid_out)
		|-> $stable(byte_swap_out) && $stable(integ_shift_left_out))
		else $error("cfg changed");
	a_reset_state: assert property (
		$fell(rst_in) |-> !console_break_out && !nmi_out
		&& integ_chan_sel_out && !byte_cfg_valid_out)
		else $error("reset state");
endmodule
bind schd_decode schd_decode_assertions chk_u (.*);
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the host port decoder
`include "schd_consts.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] base_c = `SCHD_PERIPH_BASE;
	logic clk_in, rst_in, console_rxd_in, ale_in, rd_n_in, wr_n_in, bhe_n_in;
	logic [15:0] ad_in;
	logic addr_strobe_n_out, ctrl_rd_n_out, ctrl_wr_n_out, dual_cs_n_out;
	logic dual_chan_a_out, integ_cs_n_out, serial_or_dma_select_out;
	logic integ_chan_sel_out, integ_cfg_access_out, multi_cs_n_out;
	logic port_select_out, data_cmd_sel_out, multi_wide_out;
	logic multi_cfg_access_out, byte_cfg_valid_out, byte_swap_out;
	logic even_low_lane_out, integ_dbl_ack_out, integ_shift_left_out;
	logic word_cfg_valid_out, word_cfg_fault_out, multi_bus16_out;
	logic multi_dbl_ack_out, multi_shift_right_out, console_break_out, nmi_out;
	logic [3:0] dual_reg_out;
	logic [4:0] integ_reg_out;
	logic [6:0] multi_reg_out;
	int mismatches, num_checks, cycles;
	logic [15:0] dual_t [4] = '{16'h0022, 16'h007e, 16'h0023, 16'h0042};
	logic brk_t [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	// Design and host model
	schd_decode dut_u (.clk_in, .rst_in, .ad_in, .ale_in, .rd_n_in, .wr_n_in,
		.bhe_n_in, .console_rxd_in, .addr_strobe_n_out, .ctrl_rd_n_out,
		.ctrl_wr_n_out, .dual_cs_n_out, .dual_chan_a_out, .dual_reg_out,
		.integ_cs_n_out, .serial_or_dma_select_out, .integ_chan_sel_out,
		.integ_reg_out, .integ_cfg_access_out, .multi_cs_n_out,
		.port_select_out, .data_cmd_sel_out, .multi_wide_out, .multi_reg_out,
		.multi_cfg_access_out, .byte_cfg_valid_out, .byte_swap_out,
		.even_low_lane_out, .integ_dbl_ack_out, .integ_shift_left_out,
		.word_cfg_valid_out, .word_cfg_fault_out, .multi_bus16_out,
		.multi_dbl_ack_out, .multi_shift_right_out, .console_break_out,
		.nmi_out);
	schd_host_model host_u (.clk_in, .ad_out(ad_in), .ale_out(ale_in),
		.rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .bhe_n_out(bhe_n_in));

	// Clock generation
	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	// Hang guard
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			final_report();
		end
	end

	task automatic check(input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic go(input logic w, input logic [15:0] off, d);
		host_u.start(w, base_c + off, d);
	endtask

	task automatic reset_for(input int n);
		rst_in = 1'b1;
		repeat (n) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clk_in);
	endtask

	task automatic final_report();
		$display("mismatches %0d, checks %0d", mismatches, num_checks);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		console_rxd_in = 1'b1;
		reset_for(12);
		check(dual_cs_n_out & integ_cs_n_out & multi_cs_n_out, 1);
		check({console_break_out, nmi_out, byte_cfg_valid_out}, 0);
		go(1'b1, 16'h0000, 16'h0003);
		host_u.finish();
		for (int i = 0; i < 4; i++)
		begin
			go(1'b0, dual_t[i], 16'h0000);
			check(dual_cs_n_out, dual_t[i][0]);
			check({dual_chan_a_out, dual_reg_out}, dual_t[i][5:1]);
			check(console_break_out, brk_t[i]);
			host_u.finish();
		end
		go(1'b0, 16'h0060, 16'h0000);
		host_u.finish();
		console_rxd_in = 1'b0;
		repeat (6) @(negedge clk_in);
		check(nmi_out, 1);
		console_rxd_in = 1'b1;
		go(1'b0, 16'h0040, 16'h0000);
		host_u.finish();
		console_rxd_in = 1'b0;
		repeat (6) @(negedge clk_in);
		check({console_break_out, nmi_out}, 0);
		console_rxd_in = 1'b1;
		go(1'b1, 16'h0080, 16'h00c6);
		check({integ_cs_n_out, serial_or_dma_select_out}, 0);
		check(integ_chan_sel_out, 1);
		check(ctrl_wr_n_out, 0);
		host_u.finish();
		check({byte_cfg_valid_out, byte_swap_out, even_low_lane_out}, 7);
		check({integ_dbl_ack_out, integ_shift_left_out}, 3);
		go(1'b0, 16'h00e4, 16'h0000);
		check({integ_cs_n_out, serial_or_dma_select_out}, 1);
		check({integ_chan_sel_out, integ_reg_out}, 6'h32);
		host_u.finish();
		go(1'b1, 16'h0080, 16'h0000);
		check(integ_cfg_access_out, 0);
		host_u.finish();
		check({byte_swap_out, integ_shift_left_out}, 3);
		go(1'b0, 16'h0081, 16'h0000);
		check(integ_cs_n_out, 1);
		host_u.finish();
		go(1'b1, 16'h0180, 16'h0007);
		check({multi_cfg_access_out, port_select_out}, 3);
		host_u.finish();
		check({word_cfg_valid_out, word_cfg_fault_out}, 2);
		check({multi_bus16_out, multi_dbl_ack_out, multi_shift_right_out}, 7);
		go(1'b0, 16'h01c5, 16'h0000);
		check({multi_cs_n_out, port_select_out, multi_wide_out}, 2);
		check(multi_reg_out, 7'h45);
		host_u.finish();
		go(1'b1, 16'h0180, 16'hffff);
		host_u.finish();
		check({word_cfg_fault_out, multi_shift_right_out}, 1);
		go(1'b0, 16'h0060, 16'h0000);
		host_u.finish();
		reset_for(4);
		check({console_break_out, byte_cfg_valid_out}, 0);
		go(1'b1, 16'h0100, 16'h0008);
		host_u.finish();
		check({word_cfg_fault_out, multi_shift_right_out}, 2);
		go(1'b0, 16'h0102, 16'h0000);
		check({multi_cs_n_out, port_select_out, multi_wide_out}, 1);
		check(multi_reg_out, 7'h01);
		host_u.finish();
		final_report();
	end
endmodule
`default_nettype wire
